/* File: rtl/acc_pkg.sv */
// Package with register map, field positions and timing constants of the comparator control.
package acc_pkg;
   localparam logic [7:0] ADDR_CTL_ONE = 8'h59;
   localparam logic [7:0] ADDR_CTL_TWO = 8'h5A;
   localparam logic [7:0] ADDR_BUF_DIS = 8'h5B;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h5C;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h5D;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h5E;
   // Control register one field positions.
   localparam int CTL1_IRQ_FLAG = 0;
   localparam int CTL1_IRQ_EN = 1;
   localparam int CTL1_EDGE_SEL = 2;
   localparam int CTL1_POWER_ON = 3;
   localparam int CTL1_REF_LVL_LO = 4;
   localparam int CTL1_REF_TERM = 6;
   localparam int CTL1_SWAP = 7;
   // Control register two field positions.
   localparam int CTL2_RESULT = 0;
   localparam int CTL2_FILTER_EN = 1;
   localparam int CTL2_SW_POS = 2;
   localparam int CTL2_SW_NEG = 3;
   localparam logic [7:0] CTL1_RESET = 8'h00;
   localparam logic [7:0] CTL2_RESET = 8'h00;
   localparam logic [7:0] BUF_DIS_RESET = 8'h00;
   // Reference level codes.
   localparam logic [1:0] REF_OFF = 2'h0;
   localparam logic [1:0] REF_QUARTER = 2'h1;
   localparam logic [1:0] REF_HALF = 2'h2;
   localparam logic [1:0] REF_DIODE = 2'h3;
   // Digital low-pass filter: result must hold this long to pass.
   localparam int CLK_PERIOD_NS = 50;
   localparam int FILTER_TIME_NS = 800;
   localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILTER_CW = 5;
endpackage

/* File: rtl/acc_filter.sv */
// Digital low-pass filter that passes a level only after it has held steady.
`timescale 1ns/100ps
module acc_filter
   import acc_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   // Data.
   input wire logic raw_i,
   output logic filt_o
);
   logic [FILTER_CW-1:0] count;

   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         count <= '0;
         filt_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (raw_i == filt_o)
            count <= '0;
         else if (count == FILTER_CW'(FILTER_CYCLES - 1))
         begin
            count <= '0;
            filt_o <= raw_i;
         end
         else
            count <= count + FILTER_CW'(1);
      end
   end

   stable_change_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (filt_o != $past(filt_o)) |-> $past(count) == FILTER_CW'(FILTER_CYCLES - 1))
      else $error("Filter output changed before the hold time.");
endmodule // acc_filter

/* File: rtl/acc_ctrl.sv */
// Digital control and interrupt wrapper of an on-chip analog comparator.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
module acc_ctrl
   import acc_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   // Register port.
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Interrupt controller.
   input wire logic global_irq_enable_i,
   input wire logic irq_ack_i,
   output logic irq_req_o,
   output logic irq_o,
   // Analog comparator core.
   input wire logic core_out_i,
   output logic core_power_on_o,
   output logic core_swap_o,
   output logic ref_to_pos_o,
   output logic ref_to_neg_o,
   output logic [1:0] ref_level_o,
   output logic sw_pos_o,
   output logic sw_neg_o,
   // Port pins and timer.
   output logic [7:0] pin_buffer_disable_o,
   output logic timer_capture_input_b_o
);
   logic input_swap;
   logic reference_terminal_select;
   logic [1:0] reference_level_select;
   logic comparator_power_on;
   logic irq_edge_select;
   logic comparator_irq_enable;
   logic comparator_irq_flag;
   logic output_filter_enable;
   logic sw_pos;
   logic sw_neg;
   logic [7:0] port_buffer_disable;
   logic [1:0] irq_status;
   logic [1:0] irq_enable;
   logic sync1;
   logic sync2;
   logic sync3;
   logic raw_level;
   logic filt_level;
   logic comparator_result;
   logic result_d;
   logic edge_hit;
   logic rise;
   logic fall;
   logic wr_ctl1;
   logic [7:0] ctl1_val;
   logic [7:0] ctl2_val;

   // Three stage synchroniser; a change counts once stages two and three agree.
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         raw_level <= 1'b0;
      end
      else if (clk_en_i)
      begin
         sync1 <= core_out_i;
         sync2 <= sync1;
         sync3 <= sync2;
         if (sync2 == sync3)
            raw_level <= sync3 ^ input_swap;
      end
   end

   acc_filter u_filter
   (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .clk_en_i(clk_en_i),
      .raw_i(raw_level),
      .filt_o(filt_level)
   );

   // The powered-off gate sits after the filter so a stale filtered level never leaks out.
   assign comparator_result = comparator_power_on &
      (output_filter_enable ? filt_level : raw_level);
   assign timer_capture_input_b_o = comparator_result;

   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
         result_d <= 1'b0;
      else if (clk_en_i)
         result_d <= comparator_result;
   end

   assign rise = comparator_result & ~result_d;
   assign fall = ~comparator_result & result_d;
   assign edge_hit = irq_edge_select ? fall : rise;

   assign wr_ctl1 = wr_i && addr_i == ADDR_CTL_ONE;

   // Control register one; the flag is set by hardware with priority over any clear.
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         input_swap <= CTL1_RESET[CTL1_SWAP];
         reference_terminal_select <= CTL1_RESET[CTL1_REF_TERM];
         reference_level_select <= CTL1_RESET[CTL1_REF_LVL_LO +: 2];
         comparator_power_on <= CTL1_RESET[CTL1_POWER_ON];
         irq_edge_select <= CTL1_RESET[CTL1_EDGE_SEL];
         comparator_irq_enable <= CTL1_RESET[CTL1_IRQ_EN];
         comparator_irq_flag <= CTL1_RESET[CTL1_IRQ_FLAG];
      end
      else if (clk_en_i)
      begin
         if (wr_ctl1)
         begin
            input_swap <= wdata_i[CTL1_SWAP];
            reference_terminal_select <= wdata_i[CTL1_REF_TERM];
            reference_level_select <= wdata_i[CTL1_REF_LVL_LO +: 2];
            comparator_power_on <= wdata_i[CTL1_POWER_ON];
            irq_edge_select <= wdata_i[CTL1_EDGE_SEL];
            comparator_irq_enable <= wdata_i[CTL1_IRQ_EN];
         end
         if (edge_hit)
            comparator_irq_flag <= 1'b1;
         else if (irq_ack_i)
            comparator_irq_flag <= 1'b0;
         else if (wr_ctl1)
            comparator_irq_flag <= wdata_i[CTL1_IRQ_FLAG];
      end
   end

   // Control register two and port buffer disables.
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         output_filter_enable <= CTL2_RESET[CTL2_FILTER_EN];
         sw_pos <= CTL2_RESET[CTL2_SW_POS];
         sw_neg <= CTL2_RESET[CTL2_SW_NEG];
         port_buffer_disable <= BUF_DIS_RESET;
      end
      else if (clk_en_i && wr_i)
      begin
         if (addr_i == ADDR_CTL_TWO)
         begin
            output_filter_enable <= wdata_i[CTL2_FILTER_EN];
            sw_pos <= wdata_i[CTL2_SW_POS];
            sw_neg <= wdata_i[CTL2_SW_NEG];
         end
         if (addr_i == ADDR_BUF_DIS)
            port_buffer_disable <= wdata_i;
      end
   end

   // Sticky status: bit 0 rising, bit 1 falling result transition; set wins over clear.
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         irq_status <= 2'h0;
         irq_enable <= 2'h0;
      end
      else if (clk_en_i)
      begin
         if (wr_i && addr_i == ADDR_IRQ_ENABLE)
            irq_enable <= wdata_i[1:0];
         for (int i = 0; i < 2; i++)
         begin
            if ((i == 0) ? rise : fall)
               irq_status[i] <= 1'b1;
            else if (wr_i && addr_i == ADDR_IRQ_CLEAR && wdata_i[i])
               irq_status[i] <= 1'b0;
         end
      end
   end

   assign irq_o = |(irq_status & irq_enable);
   assign irq_req_o = comparator_irq_flag & comparator_irq_enable
      & global_irq_enable_i;

   // Analog controls.
   assign core_power_on_o = comparator_power_on;
   assign core_swap_o = input_swap;
   assign ref_level_o = reference_level_select;
   assign ref_to_neg_o = (reference_level_select != REF_OFF)
      & (reference_terminal_select ^ input_swap);
   assign ref_to_pos_o = (reference_level_select != REF_OFF)
      & ~(reference_terminal_select ^ input_swap);
   assign sw_pos_o = sw_pos;
   assign sw_neg_o = sw_neg;
   assign pin_buffer_disable_o = port_buffer_disable;

   assign ctl1_val = {input_swap, reference_terminal_select, reference_level_select,
      comparator_power_on, irq_edge_select, comparator_irq_enable, comparator_irq_flag};
   assign ctl2_val = {4'h0, sw_neg, sw_pos, output_filter_enable, comparator_result};

   // Read data stands for exactly the cycle after the read strobe.
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
         rdata_o <= 8'h00;
      else if (clk_en_i)
      begin
         rdata_o <= 8'h00;
         if (rd_i)
         begin
            unique case (addr_i)
               ADDR_CTL_ONE: rdata_o <= ctl1_val;
               ADDR_CTL_TWO: rdata_o <= ctl2_val;
               ADDR_BUF_DIS: rdata_o <= port_buffer_disable;
               ADDR_IRQ_STATUS: rdata_o <= {6'h00, irq_status};
               ADDR_IRQ_ENABLE: rdata_o <= {6'h00, irq_enable};
               default: rdata_o <= 8'h00;
            endcase
         end
      end
   end

   power_off_low_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      !comparator_power_on |-> !comparator_result)
      else $error("Result not low while powered off.");

   flag_on_edge_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && edge_hit) |=> comparator_irq_flag)
      else $error("Selected edge did not set the flag.");

   edge_polarity_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && !irq_edge_select && $rose(comparator_result)
       && $stable(irq_edge_select)) |=> comparator_irq_flag)
      else $error("Rising edge missed with edge select zero.");

   fall_polarity_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && irq_edge_select && $fell(comparator_result)
       && $stable(irq_edge_select)) |=> comparator_irq_flag)
      else $error("Falling edge missed with edge select one.");

   irq_gate_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      irq_req_o |-> (comparator_irq_flag && comparator_irq_enable
      && global_irq_enable_i))
      else $error("Interrupt request without all enables.");

   ack_clears_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && irq_ack_i && !edge_hit) |=> !comparator_irq_flag)
      else $error("Serviced flag did not clear.");

   flag_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && comparator_irq_flag && !irq_ack_i && !wr_ctl1) |=> comparator_irq_flag)
      else $error("Flag cleared without service or write.");

   sw_clear_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && wr_ctl1 && !wdata_i[CTL1_IRQ_FLAG] && !edge_hit) |=> !comparator_irq_flag)
      else $error("Software write did not clear the flag.");

   status_rise_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && rise) |=> irq_status[0])
      else $error("Rising transition not recorded in status.");

   status_fall_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && fall) |=> irq_status[1])
      else $error("Falling transition not recorded in status.");

   status_clear_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && wr_i && addr_i == ADDR_IRQ_CLEAR && wdata_i[0] && !rise) |=> !irq_status[0])
      else $error("Status bit survived its clear.");

   timer_same_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      timer_capture_input_b_o == comparator_result)
      else $error("Timer capture differs from result.");

   ref_route_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (reference_level_select != REF_OFF && !input_swap && !reference_terminal_select)
      |-> (ref_to_pos_o && !ref_to_neg_o))
      else $error("Reference on wrong terminal.");

   ref_swap_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (reference_level_select != REF_OFF && input_swap && !reference_terminal_select)
      |-> (ref_to_neg_o && !ref_to_pos_o))
      else $error("Swap did not move the reference.");

   ref_off_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (reference_level_select == REF_OFF) |-> (!ref_to_pos_o && !ref_to_neg_o))
      else $error("Reference routed while switched off.");

   // Register writes are left out because a control change lands on the same edge.
   sync_delay_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && !input_swap && !output_filter_enable && comparator_power_on
       && core_out_i && !wr_i) [*4] |=> comparator_result)
      else $error("Synchronised result late.");

   sync_once_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && sync2 != sync3) |=> $stable(raw_level))
      else $error("Result changed before the synchroniser settled.");

   swap_invert_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && input_swap && !output_filter_enable && comparator_power_on
       && !core_out_i) [*5] |-> comparator_result)
      else $error("Swap did not invert the result.");

   result_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && rd_i && addr_i == ADDR_CTL_TWO)
      |=> rdata_o[CTL2_RESULT] == $past(comparator_result))
      else $error("Read result differs from the comparator result.");

   bufdis_write_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && wr_i && addr_i == ADDR_BUF_DIS) |=> pin_buffer_disable_o == $past(wdata_i))
      else $error("Buffer disable write not applied.");

   power_write_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && wr_ctl1) |=> core_power_on_o == $past(wdata_i[CTL1_POWER_ON]))
      else $error("Power control write not applied.");
endmodule // acc_ctrl

/* File: tb/acc_core_model.sv */
// Behavioural model of the analog comparator core and reference network.
`timescale 1ns/100ps
module acc_core_model
   import acc_pkg::*;
(
   // Controls from the wrapper.
   input wire logic swap_i,
   input wire logic ref_to_pos_i,
   input wire logic ref_to_neg_i,
   input wire logic [1:0] ref_level_i,
   input wire logic sw_pos_i,
   input wire logic sw_neg_i,
   // Pin levels in millivolts.
   input wire logic [11:0] pin_pos_i,
   input wire logic [11:0] pin_neg_i,
   // Raw decision.
   output logic core_out_o
);
   logic [11:0] vref;
   logic [11:0] line_pos;
   logic [11:0] line_neg;
   logic [11:0] p;
   logic [11:0] n;
   // The core keeps deciding while powered off, so forcing low is left to the wrapper.
   // Swap exchanges only the pin lines; the wrapper already names the terminal that
   // carries the reference after the exchange.
   always_comb
   begin
      case (ref_level_i)
         REF_QUARTER: vref = 12'h339;
         REF_HALF: vref = 12'h672;
         REF_DIODE: vref = 12'h226;
         default: vref = 12'h000;
      endcase
      line_pos = sw_pos_i ? pin_pos_i : 12'h000;
      line_neg = sw_neg_i ? pin_neg_i : 12'h000;
      p = ref_to_pos_i ? vref : (swap_i ? line_neg : line_pos);
      n = ref_to_neg_i ? vref : (swap_i ? line_pos : line_neg);
      core_out_o = p > n;
   end
endmodule // acc_core_model

/* File: tb/analog_comparator_control_tb.sv */
// Self-checking testbench of the comparator control wrapper.
`timescale 1ns/100ps
module analog_comparator_control_tb;
   import acc_pkg::*;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic clk_en_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic global_irq_enable_i = 1'b0;
   logic irq_ack_i = 1'b0;
   logic [7:0] rdata_o;
   logic irq_req_o;
   logic irq_o;
   logic core_out_i;
   logic core_power_on_o;
   logic core_swap_o;
   logic ref_to_pos_o;
   logic ref_to_neg_o;
   logic [1:0] ref_level_o;
   logic sw_pos_o;
   logic sw_neg_o;
   logic [7:0] pin_buffer_disable_o;
   logic timer_capture_input_b_o;
   logic [11:0] pin = 12'h000;
   logic [15:0] lfsr = 16'h4A9C;
   logic [7:0] c1;
   int error_cnt = 0;
   int checked = 0;

   always #25 sys_clk_i = ~sys_clk_i;

   acc_ctrl uut (.sys_clk_i, .resetn_i, .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .global_irq_enable_i, .irq_ack_i, .irq_req_o, .irq_o, .core_out_i, .core_power_on_o,
      .core_swap_o, .ref_to_pos_o, .ref_to_neg_o, .ref_level_o, .sw_pos_o, .sw_neg_o,
      .pin_buffer_disable_o, .timer_capture_input_b_o);

   acc_core_model core (.swap_i(core_swap_o), .ref_to_pos_i(ref_to_pos_o),
      .ref_to_neg_i(ref_to_neg_o), .ref_level_i(ref_level_o), .sw_pos_i(sw_pos_o),
      .sw_neg_i(sw_neg_o), .pin_pos_i(pin), .pin_neg_i(12'h000), .core_out_o(core_out_i));

   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Pin against the quarter-supply reference on the negative terminal.
   function automatic logic [7:0] above(input logic [11:0] v);
      return 8'(v > 12'h339);
   endfunction

   function automatic logic [7:0] ref_on(input logic [7:0] c, input logic neg);
      return 8'((c[5:4] != REF_OFF) && ((c[6] ^ c[7]) == neg));
   endfunction

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic results();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Ends on a falling edge so that outputs have settled.
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e,
      input logic [7:0] m);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(negedge sys_clk_i);
      chk(nm, rdata_o & m, e & m);
   endtask

   initial
   begin
      #500000;
      error_cnt++;
      results();
   end

   initial
   begin
      repeat (3) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      // Reset values, the last two addresses are unmapped.
      for (int i = 0; i < 8; i++)
         rdc("reset", 8'(8'h59 + i), 8'h00, 8'hFF);
      // A write while the clock enable is low must leave the register alone.
      @(posedge sys_clk_i);
      clk_en_i <= 1'b0;
      wr(ADDR_BUF_DIS, 8'hA5);
      clk_en_i <= 1'b1;
      rdc("frozen", ADDR_BUF_DIS, 8'h00, 8'hFF);
      for (int i = 0; i < 12; i++)
      begin
         lfsr = nxt(lfsr);
         c1 = {lfsr[7:6], 2'(i), lfsr[3:1], 1'b0};
         wr(ADDR_CTL_ONE, c1);
         wr(ADDR_CTL_TWO, lfsr[15:8]);
         wr(ADDR_BUF_DIS, lfsr[15:8]);
         rdc("ctl1", ADDR_CTL_ONE, c1, 8'hFE);
         rdc("ctl2", ADDR_CTL_TWO, lfsr[15:8] & 8'h0E, 8'hFE);
         chk("pwr", 8'(core_power_on_o), 8'(c1[3]));
         chk("swap", 8'(core_swap_o), 8'(c1[7]));
         chk("lvl", 8'(ref_level_o), 8'(c1[5:4]));
         chk("rpos", 8'(ref_to_pos_o), ref_on(c1, 1'b0));
         chk("rneg", 8'(ref_to_neg_o), ref_on(c1, 1'b1));
         chk("swp", 8'(sw_pos_o), 8'(lfsr[10]));
         chk("swn", 8'(sw_neg_o), 8'(lfsr[11]));
         chk("bufdis", pin_buffer_disable_o, lfsr[15:8]);
      end
      // Swap and filter in all four pairings against random pin levels.
      for (int i = 0; i < 16; i++)
      begin
         lfsr = nxt(lfsr);
         wr(ADDR_CTL_ONE, i[0] ? 8'hD8 : 8'h58);
         wr(ADDR_CTL_TWO, {6'h01, i[1], 1'b0});
         pin <= {1'b0, lfsr[10:1], 1'b0};
         cyc(24);
         chk("timer", 8'(timer_capture_input_b_o), above(pin));
         rdc("result", ADDR_CTL_TWO, above(pin), 8'h01);
         chk("rneg", 8'(ref_to_neg_o), 8'(!i[0]));
         chk("rpos", 8'(ref_to_pos_o), 8'(i[0]));
      end
      wr(ADDR_CTL_ONE, 8'h50);
      pin <= 12'hFFF;
      cyc(24);
      chk("off", 8'(timer_capture_input_b_o), 8'h00);
      // A short pulse must not pass the filter.
      wr(ADDR_CTL_ONE, 8'h58);
      wr(ADDR_CTL_TWO, 8'h06);
      pin <= 12'h000;
      cyc(24);
      @(posedge sys_clk_i);
      pin <= 12'hFFF;
      repeat (6) @(posedge sys_clk_i);
      pin <= 12'h000;
      repeat (30)
      begin
         cyc(0);
         chk("pulse", 8'(timer_capture_input_b_o), 8'h00);
         @(posedge sys_clk_i);
      end
      wr(ADDR_CTL_ONE, 8'h5A);
      wr(ADDR_IRQ_ENABLE, 8'h01);
      // Earlier scenarios left both sticky bits set.
      wr(ADDR_IRQ_CLEAR, 8'h03);
      global_irq_enable_i <= 1'b1;
      pin <= 12'hFFF;
      cyc(24);
      chk("req", 8'(irq_req_o), 8'h01);
      chk("irq", 8'(irq_o), 8'h01);
      rdc("flag", ADDR_CTL_ONE, 8'h5B, 8'hFF);
      rdc("stat", ADDR_IRQ_STATUS, 8'h01, 8'h03);
      @(posedge sys_clk_i);
      global_irq_enable_i <= 1'b0;
      cyc(0);
      chk("req", 8'(irq_req_o), 8'h00);
      @(posedge sys_clk_i);
      irq_ack_i <= 1'b1;
      @(posedge sys_clk_i);
      irq_ack_i <= 1'b0;
      rdc("ack", ADDR_CTL_ONE, 8'h5A, 8'hFF);
      wr(ADDR_IRQ_CLEAR, 8'h01);
      cyc(1);
      chk("irq", 8'(irq_o), 8'h00);
      // Falling edge selected: the fall sets the flag, a rise does not.
      wr(ADDR_CTL_ONE, 8'h5E);
      wr(ADDR_IRQ_ENABLE, 8'h02);
      pin <= 12'h000;
      cyc(24);
      rdc("fall", ADDR_CTL_ONE, 8'h5F, 8'hFF);
      rdc("stat", ADDR_IRQ_STATUS, 8'h02, 8'h03);
      chk("irq", 8'(irq_o), 8'h01);
      wr(ADDR_IRQ_ENABLE, 8'h00);
      cyc(1);
      chk("mask", 8'(irq_o), 8'h00);
      wr(ADDR_CTL_ONE, 8'h5E);
      rdc("swclr", ADDR_CTL_ONE, 8'h5E, 8'hFF);
      @(posedge sys_clk_i);
      pin <= 12'hFFF;
      cyc(24);
      rdc("rise", ADDR_CTL_ONE, 8'h5E, 8'hFF);
      results();
   end
endmodule // analog_comparator_control_tb
